/* File: hw/vcp_serial_port.sv */
// Serial sample port and power control of a voice-band codec.
// Assumes frame syncs and data come from host logic clocked by the
// master or bit clock they belong to; bit clocks may stop between frames.
`default_nettype none

// Summary of operation
// - Words travel MSB first both ways
// - Eight bits companded, sixteen bits linear
// - Outputs float about 39 frames after power-up
// - Outputs float when master clock stops in variable rate only
// - Low power-down pin powers down; pulled high
// - Power-down floats outputs regardless of syncs
// - Both syncs low puts whole device standby
// - Receive sync low idles receive only
// - Transmit sync low floats transmit within frames
// - Bit clock pin tied high selects fixed rate
// - Fixed rate shifts out on rising master clock
// - Fixed rate samples in on falling master clock
// - Strobe low from bit one to last bit
// - Output floats after last bit's falling edge
// - Bit clock on pin selects variable rate
// - Variable rate shifts out on bit clock rising
// - Variable rate captures on bit clock falling
// - Variable rate repeats word while sync high
// - Variable rate floats output after sync falls
// - Linear samples are 13-bit two's complement
// - Three trailing bits set 3 dB attenuation steps
module vcp_serial_port #(
  parameter int PowerupClks = vcp_pkg::POWERUP_CLKS
) (
  input  wire logic             mclk,
  input  wire logic             resetn,
  input  wire logic             txBitClk,
  input  wire logic             rxBitClk,
  input  wire logic             txFrameSync,
  input  wire logic             rxFrameSync,
  input  wire logic             powerDownN,
  input  wire logic             linearSel,
  input  wire logic             sampleIn,
  input  wire vcp_pkg::vcp_tx_t txSample,
  output logic                  sampleOut,
  output logic                  sampleOutOeN,
  output logic                  txSlotStrobeN,
  output logic                  txSlotStrobeOeN,
  output vcp_pkg::vcp_rx_t      rxWord,
  output logic                  rxValid,
  output logic                  varRateMode,
  output logic                  txStandby,
  output logic                  rxStandby
);

  // Reset release, one copy per domain
  logic [1:0] rstM_reg;
  logic [1:0] rstT_reg;
  logic [1:0] rstR_reg;
  logic       rstN;
  logic       rstTN;
  logic       rstRN;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) rstM_reg <= 2'h0;
    else         rstM_reg <= {rstM_reg[0], 1'b1};
  end
  always_ff @(posedge txBitClk or negedge resetn) begin
    if (!resetn) rstT_reg <= 2'h0;
    else         rstT_reg <= {rstT_reg[0], 1'b1};
  end
  always_ff @(negedge rxBitClk or negedge resetn) begin
    if (!resetn) rstR_reg <= 2'h0;
    else         rstR_reg <= {rstR_reg[0], 1'b1};
  end
  assign rstN  = rstM_reg[1];
  assign rstTN = rstT_reg[1];
  assign rstRN = rstR_reg[1];

  // Master clock domain state
  vcp_pkg::vcp_pstate_t pState_reg,    pState_next;
  logic [13:0]          pwrCnt_reg,    pwrCnt_next;
  logic [8:0]           rxHighCnt_reg, rxHighCnt_next;
  logic [1:0]           fsPrev_reg;
  logic                 fixBusy_reg,   fixBusy_next;
  logic [4:0]           fixCnt_reg,    fixCnt_next;
  logic [15:0]          fixShift_reg,  fixShift_next;
  logic [15:0]          txHold_reg,    txHold_next;
  logic                 txTgl_reg,     txTgl_next;
  logic                 mclkTgl_reg;
  logic                 rxVarPrev_reg;
  logic                 rxFixPrev_reg;
  vcp_pkg::vcp_rx_t     rxWord_reg,    rxWord_next;
  logic                 rxValid_reg,   rxValid_next;
  logic [8:0]           idleCnt_reg [2];
  logic [1:0]           idle;

  // Falling-edge receive state, same clock
  logic        rxFsPrevN_reg;
  logic [4:0]  rxCntN_reg,   rxCntN_next;
  logic [15:0] rxShN_reg,    rxShN_next;
  logic        rxFixTgl_reg, rxFixTgl_next;

  // Link domain state
  logic [15:0] txCur_reg,    txCur_next;
  logic [15:0] txVarSh_reg,  txVarSh_next;
  logic [4:0]  txVarCnt_reg, txVarCnt_next;
  logic        txTglPrev_reg;
  logic        mclkPrev_reg;
  logic [4:0]  stopCnt_reg,  stopCnt_next;
  logic [4:0]  rxVarCnt_reg, rxVarCnt_next;
  logic [15:0] rxVarSh_reg,  rxVarSh_next;
  logic [15:0] rxVarHold_reg, rxVarHold_next;
  logic        rxVarTgl_reg, rxVarTgl_next;

  logic pdnS, linS, rxClkS, rxVarTglS;
  logic txEnS, txLinS, txTglS, mclkTglS;
  logic rxEnS, rxLinS;
  logic running, varMode, txActive, rxActive, txRise, fixStart;
  logic fixDrive, varDrive, mclkStopped;
  logic [4:0]  wordLen;
  logic [15:0] txWordNow;

  vcp_sync2 #(.Width(4), .FallEdge(1'b0)) uSyncM (
    .clk  (mclk),
    .rstN (rstN),
    .d    ({powerDownN, linearSel, rxBitClk, rxVarTgl_reg}),
    .q    ({pdnS, linS, rxClkS, rxVarTglS})
  );
  vcp_sync2 #(.Width(4), .FallEdge(1'b0)) uSyncT (
    .clk  (txBitClk),
    .rstN (rstTN),
    .d    ({txActive & varMode, linearSel, txTgl_reg, mclkTgl_reg}),
    .q    ({txEnS, txLinS, txTglS, mclkTglS})
  );
  vcp_sync2 #(.Width(2), .FallEdge(1'b1)) uSyncR (
    .clk  (rxBitClk),
    .rstN (rstRN),
    .d    ({rxActive & varMode, linearSel}),
    .q    ({rxEnS, rxLinS})
  );

  // Sync held low for a whole frame counts as idle
  for (genvar i = 0; i < 2; i++) begin : gIdle
    logic       fs;
    logic [8:0] cntNext;
    assign fs = (i == 0) ? txFrameSync : rxFrameSync;
    always_comb begin
      cntNext = idleCnt_reg[i];
      if (fs && !fsPrev_reg[i]) begin
        cntNext = 9'h000;
      end else if (idleCnt_reg[i] != vcp_pkg::FRAME_CLKS) begin
        cntNext = idleCnt_reg[i] + 9'h001;
      end
    end
    always_ff @(posedge mclk or negedge rstN) begin
      if (!rstN) idleCnt_reg[i] <= vcp_pkg::FRAME_CLKS;
      else       idleCnt_reg[i] <= cntNext;
    end
    assign idle[i] = idleCnt_reg[i] == vcp_pkg::FRAME_CLKS;
  end

  assign running   = pState_reg == vcp_pkg::PS_RUN;
  assign varMode   = rxHighCnt_reg != vcp_pkg::FRAME_CLKS;
  assign txActive  = running && !idle[0];
  assign rxActive  = running && !idle[1];
  assign txRise    = txFrameSync && !fsPrev_reg[0];
  assign wordLen   = vcp_pkg::vcp_word_len(linS);
  assign txWordNow = vcp_pkg::vcp_tx_word(txSample, linS);
  assign fixStart  = txRise && txActive && !varMode && !fixBusy_reg;

  always_comb begin
    pState_next    = pState_reg;
    pwrCnt_next    = pwrCnt_reg;
    rxHighCnt_next = rxHighCnt_reg;
    fixBusy_next   = fixBusy_reg;
    fixCnt_next    = fixCnt_reg;
    fixShift_next  = fixShift_reg;
    txHold_next    = txHold_reg;
    txTgl_next     = txTgl_reg;
    rxWord_next    = rxWord_reg;
    rxValid_next   = 1'b0;
    case (pState_reg)
      vcp_pkg::PS_HOLD: begin
        pwrCnt_next = pwrCnt_reg + 14'h0001;
        if (pwrCnt_reg == 14'(PowerupClks - 1)) begin
          pState_next = pdnS ? vcp_pkg::PS_RUN : vcp_pkg::PS_DOWN;
        end
      end
      vcp_pkg::PS_RUN:  if (!pdnS) pState_next = vcp_pkg::PS_DOWN;
      vcp_pkg::PS_DOWN: if (pdnS)  pState_next = vcp_pkg::PS_RUN;
      default:          pState_next = vcp_pkg::PS_HOLD;
    endcase
    if (!rxClkS)                                   rxHighCnt_next = 9'h000;
    else if (rxHighCnt_reg != vcp_pkg::FRAME_CLKS) begin
      rxHighCnt_next = rxHighCnt_reg + 9'h001;
    end
    if (fixStart) begin
      fixBusy_next  = 1'b1;
      fixCnt_next   = 5'h01;
      fixShift_next = txWordNow;
    end else if (fixBusy_reg) begin
      if (fixCnt_reg == wordLen) fixBusy_next = 1'b0;
      else begin
        fixCnt_next   = fixCnt_reg + 5'h01;
        fixShift_next = {fixShift_reg[14:0], 1'b0};
      end
    end
    if (txRise && varMode && txActive) begin
      txHold_next = txWordNow;
      txTgl_next  = !txTgl_reg;
    end
    if (varMode && rxVarTglS != rxVarPrev_reg) begin
      rxWord_next  = vcp_pkg::vcp_rx_decode(rxVarHold_reg, linS);
      rxValid_next = 1'b1;
    end else if (!varMode && rxFixTgl_reg != rxFixPrev_reg) begin
      rxWord_next  = vcp_pkg::vcp_rx_decode(rxShN_reg, linS);
      rxValid_next = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      pState_reg    <= vcp_pkg::PS_HOLD;
      pwrCnt_reg    <= 14'h0000;
      rxHighCnt_reg <= 9'h000;
      fsPrev_reg    <= 2'h0;
      fixBusy_reg   <= 1'b0;
      fixCnt_reg    <= 5'h00;
      fixShift_reg  <= 16'h0000;
      txHold_reg    <= 16'h0000;
      txTgl_reg     <= 1'b0;
      mclkTgl_reg   <= 1'b0;
      rxVarPrev_reg <= 1'b0;
      rxFixPrev_reg <= 1'b0;
      rxWord_reg    <= '0;
      rxValid_reg   <= 1'b0;
    end else begin
      pState_reg    <= pState_next;
      pwrCnt_reg    <= pwrCnt_next;
      rxHighCnt_reg <= rxHighCnt_next;
      fsPrev_reg    <= {rxFrameSync, txFrameSync};
      fixBusy_reg   <= fixBusy_next;
      fixCnt_reg    <= fixCnt_next;
      fixShift_reg  <= fixShift_next;
      txHold_reg    <= txHold_next;
      txTgl_reg     <= txTgl_next;
      mclkTgl_reg   <= !mclkTgl_reg;
      rxVarPrev_reg <= rxVarTglS;
      rxFixPrev_reg <= rxFixTgl_reg;
      rxWord_reg    <= rxWord_next;
      rxValid_reg   <= rxValid_next;
    end
  end

  // Fixed-rate receive on the falling master clock edge
  always_comb begin
    rxCntN_next   = rxCntN_reg;
    rxShN_next    = rxShN_reg;
    rxFixTgl_next = rxFixTgl_reg;
    if (rxFrameSync && !rxFsPrevN_reg && rxActive && !varMode) begin
      rxCntN_next = 5'h01;
      rxShN_next  = {15'h0000, sampleIn};
    end else if (rxCntN_reg != 5'h00 && rxCntN_reg != wordLen) begin
      rxCntN_next = rxCntN_reg + 5'h01;
      rxShN_next  = {rxShN_reg[14:0], sampleIn};
      if (rxCntN_reg + 5'h01 == wordLen) rxFixTgl_next = !rxFixTgl_reg;
    end
  end

  always_ff @(negedge mclk or negedge rstN) begin
    if (!rstN) begin
      rxFsPrevN_reg <= 1'b0;
      rxCntN_reg    <= 5'h00;
      rxShN_reg     <= 16'h0000;
      rxFixTgl_reg  <= 1'b0;
    end else begin
      rxFsPrevN_reg <= rxFrameSync;
      rxCntN_reg    <= rxCntN_next;
      rxShN_reg     <= rxShN_next;
      rxFixTgl_reg  <= rxFixTgl_next;
    end
  end

  // Variable-rate transmit; word preloads while sync is low
  always_comb begin
    txCur_next    = (txTglS != txTglPrev_reg) ? txHold_reg : txCur_reg;
    txVarSh_next  = txVarSh_reg;
    txVarCnt_next = txVarCnt_reg;
    stopCnt_next  = stopCnt_reg;
    if (mclkTglS != mclkPrev_reg) stopCnt_next = 5'h00;
    else if (!mclkStopped)        stopCnt_next = stopCnt_reg + 5'h01;
    if (!txFrameSync) begin
      txVarSh_next  = txCur_reg;
      txVarCnt_next = 5'h00;
    end else if (txVarCnt_reg + 5'h01 == vcp_pkg::vcp_word_len(txLinS)) begin
      txVarSh_next  = txCur_reg;
      txVarCnt_next = 5'h00;
    end else begin
      txVarSh_next  = {txVarSh_reg[14:0], 1'b0};
      txVarCnt_next = txVarCnt_reg + 5'h01;
    end
  end

  always_ff @(posedge txBitClk or negedge rstTN) begin
    if (!rstTN) begin
      txCur_reg     <= 16'h0000;
      txVarSh_reg   <= 16'h0000;
      txVarCnt_reg  <= 5'h00;
      txTglPrev_reg <= 1'b0;
      mclkPrev_reg  <= 1'b0;
      stopCnt_reg   <= 5'h00;
    end else begin
      txCur_reg     <= txCur_next;
      txVarSh_reg   <= txVarSh_next;
      txVarCnt_reg  <= txVarCnt_next;
      txTglPrev_reg <= txTglS;
      mclkPrev_reg  <= mclkTglS;
      stopCnt_reg   <= stopCnt_next;
    end
  end

  // Variable-rate receive, one word per sync pulse
  always_comb begin
    rxVarCnt_next  = rxVarCnt_reg;
    rxVarSh_next   = rxVarSh_reg;
    rxVarHold_next = rxVarHold_reg;
    rxVarTgl_next  = rxVarTgl_reg;
    if (!rxFrameSync) rxVarCnt_next = 5'h00;
    else if (rxVarCnt_reg == 5'h00 ? rxEnS
             : rxVarCnt_reg != vcp_pkg::vcp_word_len(rxLinS)) begin
      rxVarCnt_next = rxVarCnt_reg + 5'h01;
      rxVarSh_next  = {rxVarSh_reg[14:0], sampleIn};
      if (rxVarCnt_reg + 5'h01 == vcp_pkg::vcp_word_len(rxLinS)) begin
        rxVarHold_next = {rxVarSh_reg[14:0], sampleIn};
        rxVarTgl_next  = !rxVarTgl_reg;
      end
    end
  end

  always_ff @(negedge rxBitClk or negedge rstRN) begin
    if (!rstRN) begin
      rxVarCnt_reg  <= 5'h00;
      rxVarSh_reg   <= 16'h0000;
      rxVarHold_reg <= 16'h0000;
      rxVarTgl_reg  <= 1'b0;
    end else begin
      rxVarCnt_reg  <= rxVarCnt_next;
      rxVarSh_reg   <= rxVarSh_next;
      rxVarHold_reg <= rxVarHold_next;
      rxVarTgl_reg  <= rxVarTgl_next;
    end
  end

  // Pin drive; a frozen master clock cannot float its own flops,
  // so the stop watch lives on the bit clock and covers variable rate
  assign mclkStopped     = stopCnt_reg == vcp_pkg::MCLK_STOP_EDGES;
  assign fixDrive        = fixBusy_reg && running;
  assign varDrive        = txFrameSync && txEnS && !mclkStopped
                           && running;
  assign sampleOut       = varMode ? txVarSh_reg[15] : fixShift_reg[15];
  assign sampleOutOeN    = !(varMode ? varDrive : fixDrive);
  assign txSlotStrobeN   = 1'b0;
  assign txSlotStrobeOeN = !(fixDrive && !varMode);
  assign rxWord          = rxWord_reg;
  assign rxValid         = rxValid_reg;
  assign varRateMode     = varMode;
  assign txStandby       = idle[0];
  assign rxStandby       = idle[1];

  a_hold_floats: assert property (@(posedge mclk) disable iff (!rstN)
    pState_reg == vcp_pkg::PS_HOLD |-> sampleOutOeN && txSlotStrobeOeN)
    else $error("Outputs driven during power-up hold");
  a_pd_enter: assert property (@(posedge mclk) disable iff (!rstN)
    running && !pdnS |=> pState_reg == vcp_pkg::PS_DOWN ##1 sampleOutOeN)
    else $error("Power-down not entered");
  a_pd_floats: assert property (@(posedge mclk) disable iff (!rstN)
    pState_reg == vcp_pkg::PS_DOWN |-> sampleOutOeN && txSlotStrobeOeN)
    else $error("Outputs driven in power-down");
  a_tx_idle_float: assert property (@(posedge mclk) disable iff (!rstN)
    idle[0] && !varMode |-> sampleOutOeN && txSlotStrobeOeN)
    else $error("Transmit standby still drives");
  a_rx_idle_tx_live: assert property (@(posedge mclk) disable iff (!rstN)
    idle[1] && fixStart |=> !sampleOutOeN && !txSlotStrobeOeN)
    else $error("Transmit stopped by receive standby");
  a_fix_comp_len: assert property (@(posedge mclk) disable iff (!rstN)
    fixStart && !linS && pdnS |=> (!txSlotStrobeOeN)[*8] ##1 txSlotStrobeOeN)
    else $error("Companded slot strobe length wrong");
  a_fix_msb_first: assert property (@(posedge mclk) disable iff (!rstN)
    fixStart |=> sampleOut == $past(txWordNow[15]))
    else $error("Fixed-rate first bit is not MSB");
  a_idle_clear: assert property (@(posedge mclk) disable iff (!rstN)
    txRise |=> !idle[0] ##0 !txStandby)
    else $error("Sync edge left transmit idle");
  a_var_repeat: assert property (@(posedge txBitClk)
    disable iff (!rstTN)
    txFrameSync && txVarCnt_reg == 5'h07 && !txLinS
    |=> txVarSh_reg == $past(txCur_reg))
    else $error("Word not repeated in next slot");
  a_var_rx_done: assert property (@(negedge rxBitClk)
    disable iff (!rstRN)
    rxFrameSync && rxVarCnt_reg == 5'h07 && !rxLinS
    |=> rxVarTgl_reg != $past(rxVarTgl_reg))
    else $error("Variable-rate word not completed");

  c_fix_tx: cover property (@(posedge mclk) disable iff (!rstN)
    fixStart ##1 fixBusy_reg[*8] ##1 !fixBusy_reg);
  c_rx_word: cover property (@(posedge mclk) disable iff (!rstN) rxValid_reg);
  c_var_repeat: cover property (@(posedge txBitClk) disable iff (!rstTN)
    txFrameSync && txVarCnt_reg == 5'h07 ##1 txFrameSync);
  c_power_down: cover property (@(posedge mclk) disable iff (!rstN)
    running ##1 pState_reg == vcp_pkg::PS_DOWN);

endmodule

`default_nettype wire

/* File: hw/vcp_sync2.sv */
// Two flip-flop level synchroniser, rising or falling edge.
// Assumes each bit is a level that holds for several destination clocks.
`default_nettype none

module vcp_sync2 #(
  parameter int   Width    = 1,
  parameter logic FallEdge = 1'b0
) (
  input  wire logic             clk,
  input  wire logic             rstN,
  input  wire logic [Width-1:0] d,
  output logic      [Width-1:0] q
);

  logic [Width-1:0] stage1_reg;
  logic [Width-1:0] stage2_reg;

  assign q = stage2_reg;

  if (FallEdge) begin : gFall
    always_ff @(negedge clk or negedge rstN) begin
      if (!rstN) begin
        stage1_reg <= '0;
        stage2_reg <= '0;
      end else begin
        stage1_reg <= d;
        stage2_reg <= stage1_reg;
      end
    end
  end else begin : gRise
    always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
        stage1_reg <= '0;
        stage2_reg <= '0;
      end else begin
        stage1_reg <= d;
        stage2_reg <= stage1_reg;
      end
    end
  end

endmodule

`default_nettype wire

/* File: include/vcp_pkg.sv */
// Constants, carriers and decode helpers for the voice codec serial port.
// Assumes a 20 MHz master clock and 256 master clocks per frame.
`default_nettype none

package vcp_pkg;

  localparam int         MCLK_KHZ        = 20000;
  localparam int         POWERUP_US      = 500;
  // Least time, so round up to whole cycles
  localparam int         POWERUP_CLKS    =
    (POWERUP_US * MCLK_KHZ + 999) / 1000;
  localparam logic [8:0] FRAME_CLKS      = 9'h100;
  localparam logic [4:0] WORD_LEN_COMP   = 5'h08;
  localparam logic [4:0] WORD_LEN_LIN    = 5'h10;
  localparam int         LIN_BITS        = 13;
  localparam int         ATTEN_BITS      = 3;
  localparam logic [4:0] ATTEN_STEP_DB   = 5'h03;
  // Bit clocks without a master clock change before the outputs float
  localparam logic [4:0] MCLK_STOP_EDGES = 5'h10;

  typedef enum logic [2:0] {
    PS_HOLD = 3'b001,
    PS_DOWN = 3'b010,
    PS_RUN  = 3'b100
  } vcp_pstate_t;

  typedef struct packed {
    logic [LIN_BITS-1:0]   linear;
    logic [7:0]            code;
  } vcp_tx_t;

  typedef struct packed {
    logic [LIN_BITS-1:0]   linear;
    logic [ATTEN_BITS-1:0] attenuationBits;
    logic [4:0]            attenDb;
    logic [7:0]            code;
  } vcp_rx_t;

  function automatic logic [4:0] vcp_word_len(input logic lin);
    return lin ? WORD_LEN_LIN : WORD_LEN_COMP;
  endfunction

  // Word is MSB aligned so bit 1 is always bit 15
  function automatic logic [15:0] vcp_tx_word(input vcp_tx_t s,
                                              input logic    lin);
    return lin ? {s.linear, 3'h0} : {s.code, 8'h00};
  endfunction

  // Received bits enter at bit 0, so a short word sits low
  function automatic vcp_rx_t vcp_rx_decode(input logic [15:0] w,
                                            input logic        lin);
    vcp_rx_t r;
    r.linear          = w[15:3];
    r.attenuationBits = lin ? w[2:0] : 3'h0;
    r.attenDb         = 5'({2'h0, r.attenuationBits} * ATTEN_STEP_DB);
    r.code            = w[7:0];
    return r;
  endfunction

endpackage

`default_nettype wire

/* File: sim/test_vcp_serial_port.sv */
// Bench for the codec serial port, host model on the far side.
// Assumes the power-up hold is shortened to 20 master clocks.
`default_nettype none

module test_vcp_serial_port;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk = 1'b0, mclkRun = 1'b1, resetn = 1'b0, bitRun = 1'b1;
  logic txEn = 1'b1, rxEn = 1'b1, powerDownN = 1'b1, lin = 1'b0;
  logic [15:0] rxData = 16'h0000;
  logic txBitClk, rxBitClk, txFrameSync, rxFrameSync, sampleIn;
  logic sampleOut, sampleOutOeN, txSlotStrobeN, txSlotStrobeOeN;
  logic rxValid, varRateMode, txStandby, rxStandby;
  vcp_pkg::vcp_tx_t txSample = {13'h1a5b, 8'ha5};
  vcp_pkg::vcp_rx_t rxWord;
  int fail_count = 0;
  int n_tests = 0;

  always #25 mclk = mclkRun ? ~mclk : mclk;

  vcp_serial_port #(.PowerupClks(20)) dut (
    .mclk(mclk), .resetn(resetn), .txBitClk(txBitClk),
    .rxBitClk(rxBitClk), .txFrameSync(txFrameSync),
    .rxFrameSync(rxFrameSync), .powerDownN(powerDownN),
    .linearSel(lin), .sampleIn(sampleIn), .txSample(txSample),
    .sampleOut(sampleOut), .sampleOutOeN(sampleOutOeN),
    .txSlotStrobeN(txSlotStrobeN), .txSlotStrobeOeN(txSlotStrobeOeN),
    .rxWord(rxWord), .rxValid(rxValid), .varRateMode(varRateMode),
    .txStandby(txStandby), .rxStandby(rxStandby));

  vcp_host_model host (
    .mclk(mclk), .txEn(txEn), .rxEn(rxEn), .bitRun(bitRun),
    .rxData(rxData), .txBitClk(txBitClk), .rxBitClk(rxBitClk),
    .txFrameSync(txFrameSync), .rxFrameSync(rxFrameSync),
    .sampleIn(sampleIn));

  task automatic check(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic floatFor(input int cycles);
    repeat (cycles) begin
      @(negedge mclk);
      check("float", 16'h3, {14'h0, sampleOutOeN, txSlotStrobeOeN});
    end
  endtask

  task automatic txCheck(input logic [15:0] w, input int nb);
    @(posedge txFrameSync);
    @(posedge mclk);
    for (int i = 0; i < nb; i++) begin
      @(negedge mclk);
      check("tx slot", {13'h0, w[15-i], 2'b00},
            {13'h0, sampleOut, sampleOutOeN, txSlotStrobeOeN});
    end
    @(negedge mclk);
    check("tx end", 16'h3, {14'h0, sampleOutOeN, txSlotStrobeOeN});
    check("strobe", 16'h0, {15'h0, txSlotStrobeN});
  endtask

  task automatic rxCheck(input logic [15:0] w, input logic ln);
    @(posedge mclk) #5 rxData = w;
    @(posedge rxFrameSync);
    @(posedge rxFrameSync);
    for (int i = 0; i < 40 && rxValid !== 1'b1; i++)
      @(negedge mclk);
    check("rx valid", 16'h1, {15'h0, rxValid});
    if (ln) begin
      check("rx lin", w, {rxWord.linear, rxWord.attenuationBits});
      check("atten", {11'h0, 5'(w[2:0] * 3)}, {11'h0, rxWord.attenDb});
    end else begin
      check("rx code", {8'h0, w[15:8]}, {8'h0, rxWord.code});
    end
  endtask

  task automatic testFixed();
    floatFor(20);
    repeat (2) @(posedge txFrameSync);
    txCheck({txSample.code, 8'h00}, 8);
    rxCheck(16'h963c, 1'b0);
    @(posedge mclk) #5 lin = 1'b1;
    @(posedge txFrameSync);
    txCheck({txSample.linear, 3'h0}, 16);
    rxCheck(16'hb46f, 1'b1);
    rxCheck(16'h1232, 1'b1);
    @(posedge mclk) #5 lin = 1'b0;
    $display("done fixed rate");
  endtask

  task automatic testPower();
    logic [1:0] en [3] = '{2'b00, 2'b10, 2'b01};
    @(posedge mclk) #5 powerDownN = 1'b0;
    @(posedge txFrameSync);
    floatFor(20);
    @(posedge mclk) #5 powerDownN = 1'b1;
    @(posedge txFrameSync);
    txCheck({txSample.code, 8'h00}, 8);
    for (int k = 0; k < 3; k++) begin
      @(posedge mclk) #5 {txEn, rxEn} = en[k];
      repeat (1300) @(posedge mclk);
      @(negedge mclk);
      check("standby", {14'h0, ~en[k]}, {14'h0, txStandby, rxStandby});
      if (en[k][1])
        txCheck({txSample.code, 8'h00}, 8);
      else
        floatFor(300);
    end
    @(posedge mclk) #5 {txEn, rxEn} = 2'b11;
    $display("done power");
  endtask

  task automatic testVariable();
    @(posedge mclk) #5 bitRun = 1'b1;
    repeat (600) @(posedge mclk);
    @(negedge mclk);
    check("var mode", 16'h1, {15'h0, varRateMode});
    rxCheck(16'hff00, 1'b0);
    @(posedge txFrameSync);
    #1;
    for (int i = 0; i < 8; i++) begin
      if (i > 0) begin
        @(posedge txBitClk);
        #1;
      end
      check("var tx", {14'h0, txSample.code[7-i], 1'b0},
            {14'h0, sampleOut, sampleOutOeN});
    end
    @(negedge txFrameSync);
    @(negedge mclk);
    check("var float", 16'h1, {15'h0, sampleOutOeN});
    @(posedge txFrameSync);
    #2 mclkRun = 1'b0;
    #300;
    check("clk stop", 16'h3, {14'h0, sampleOutOeN, txSlotStrobeOeN});
    mclkRun = 1'b1;
    @(posedge mclk) #5 bitRun = 1'b0;
    repeat (600) @(posedge mclk);
    @(negedge mclk);
    check("fixed mode", 16'h0, {15'h0, varRateMode});
    $display("done variable rate");
  endtask

  initial begin
    repeat (3) @(posedge mclk);
    #5 resetn = 1'b1;
    bitRun = 1'b0;
    testFixed();
    testPower();
    testVariable();
    results();
  end

  // About 40 frames expected; allow several times that
  initial begin
    #3000000;
    fail_count++;
    results();
  end
endmodule

`default_nettype wire

/* File: sim/vcp_host_model.sv */
// Host serial port model: frame syncs, receive data, bit clocks.
// Assumes 256 master clocks per frame; drives 5 ns after master clock rising edges.
`default_nettype none

module vcp_host_model (
  input  wire logic        mclk,
  input  wire logic        txEn,
  input  wire logic        rxEn,
  input  wire logic        bitRun,
  input  wire logic [15:0] rxData,
  output logic             txBitClk,
  output logic             rxBitClk,
  output logic             txFrameSync,
  output logic             rxFrameSync,
  output logic             sampleIn
);
  timeunit 1ns;
  timeprecision 100ps;
  int n;

  initial begin
    txBitClk = 1'b0;
    rxBitClk = 1'b1;
    txFrameSync = 1'b0;
    rxFrameSync = 1'b0;
    sampleIn = 1'b0;
    // Offset keeps bit clock edges clear of master clock and sync edges
    #1.3;
    // Bit clocks stand still when not run; receive one rests high
    forever #3 begin
      txBitClk = bitRun ? ~txBitClk : 1'b0;
      rxBitClk = bitRun ? ~rxBitClk : 1'b1;
    end
  end

  // One-cycle sync pulses aligned to the master clock
  always begin
    @(posedge mclk);
    #5;
    txFrameSync = txEn;
    rxFrameSync = rxEn;
    for (n = 0; n < 16; n++) begin
      sampleIn = rxData[15-n];
      @(posedge mclk);
      #5;
      txFrameSync = 1'b0;
      rxFrameSync = 1'b0;
    end
    // Released data line shows no stale bit
    sampleIn = ~sampleIn;
    repeat (239) @(posedge mclk);
  end
endmodule

`default_nettype wire
